// ===== hdl/conv_format_ctrl.sv
// two-channel converter register front end with data-format justification
module conv_format_ctrl
	import conv_format_pkg::*;
#(
	parameter int WORD_WIDTH = 12
) (
	input  wire logic         clk_sys_i,
	input  wire logic         reset_i,
	input  wire sfr_req_type  sfr_req_i,
	output logic [7:0]        sfr_rdata_o,
	output conv_out_type      ch0_conv_o,
	output conv_out_type      ch1_conv_o
);

	// assemble the word from high and low bytes per format code
	function automatic logic [11:0] assemble(input logic [2:0] fmt, input logic [7:0] hi, input logic [7:0] lo);
		logic [11:0] w;
		w = RESET_WORD;
		if (fmt[2]) begin
			w = {hi, lo[7:4]};
		end else begin
			case (fmt[1:0])
				2'h0: w = {hi[3:0], lo};
				2'h1: w = {hi[4:0], lo[7:1]};
				2'h2: w = {hi[5:0], lo[7:2]};
				default: w = {hi[6:0], lo[7:3]};
			endcase
		end
		return w;
	endfunction

	// word width must stay equal to the output struct field
	logic [7:0]            low_reg  [2];
	logic [7:0]            high_reg [2];
	logic [7:0]            ctrl_reg [2];
	logic [WORD_WIDTH-1:0] word_reg [2];
	logic [7:0]            rdata_next;

	// channel 0 at index 0, channel 1 at index 1; identical logic
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			localparam logic [7:0] A_LO = (ch == 0) ? ADDR_CH0_DATA_LOW : ADDR_CH1_DATA_LOW;
			localparam logic [7:0] A_HI = (ch == 0) ? ADDR_CH0_DATA_HIGH : ADDR_CH1_DATA_HIGH;
			localparam logic [7:0] A_CN = (ch == 0) ? ADDR_CH0_CONTROL : ADDR_CH1_CONTROL;
			wire logic wr_lo = sfr_req_i.write && (sfr_req_i.addr == A_LO);
			wire logic wr_hi = sfr_req_i.write && (sfr_req_i.addr == A_HI);
			wire logic wr_cn = sfr_req_i.write && (sfr_req_i.addr == A_CN);

			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					low_reg[ch] <= RESET_BYTE;
				end else if (wr_lo) begin
					low_reg[ch] <= sfr_req_i.wdata;
				end
			end

			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					high_reg[ch] <= RESET_BYTE;
				end else if (wr_hi) begin
					high_reg[ch] <= sfr_req_i.wdata;
				end
			end

			// unused bits never stored, so they read zero
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					ctrl_reg[ch] <= RESET_BYTE;
				end else if (wr_cn) begin
					ctrl_reg[ch] <= sfr_req_i.wdata & CONTROL_MASK;
				end
			end

			// latch uses the written high byte and the format of that moment,
			// so low byte first gives full resolution
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					word_reg[ch] <= RESET_WORD;
				end else if (wr_hi) begin
					word_reg[ch] <= assemble(ctrl_reg[ch][2:0], sfr_req_i.wdata, low_reg[ch]);
				end
			end
		end
	endgenerate

	// outputs: enable low shuts converter and floats pin
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ch0_conv_o <= '0;
			ch1_conv_o <= '0;
		end else begin
			ch0_conv_o.enable <= ctrl_reg[0][ENABLE_BIT];
			ch1_conv_o.enable <= ctrl_reg[1][ENABLE_BIT];
			ch0_conv_o.word   <= word_reg[0];
			ch1_conv_o.word   <= word_reg[1];
		end
	end

	always_comb begin
		rdata_next = RESET_BYTE;
		if (sfr_req_i.addr == ADDR_CH0_DATA_LOW) begin
			rdata_next = low_reg[0];
		end else if (sfr_req_i.addr == ADDR_CH0_DATA_HIGH) begin
			rdata_next = high_reg[0];
		end else if (sfr_req_i.addr == ADDR_CH0_CONTROL) begin
			rdata_next = ctrl_reg[0];
		end else if (sfr_req_i.addr == ADDR_CH1_DATA_LOW) begin
			rdata_next = low_reg[1];
		end else if (sfr_req_i.addr == ADDR_CH1_DATA_HIGH) begin
			rdata_next = high_reg[1];
		end else if (sfr_req_i.addr == ADDR_CH1_CONTROL) begin
			rdata_next = ctrl_reg[1];
		end
	end

	// registered read data, one cycle after the read request
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sfr_rdata_o <= RESET_BYTE;
		end else if (sfr_req_i.read) begin
			sfr_rdata_o <= rdata_next;
		end
	end

	property p_ctrl_unused_zero;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.read && sfr_req_i.addr == ADDR_CH1_CONTROL |=> sfr_rdata_o[6:3] == 4'h0;
	endproperty
	a_ctrl_unused_zero: assert property (p_ctrl_unused_zero) else $error("unused control bits not zero");

	property p_fmt0_ch1;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH1_DATA_HIGH && ctrl_reg[1][2:0] == 3'h0
		|=> ##1 ch1_conv_o.word == {$past(sfr_req_i.wdata[3:0], 2), $past(low_reg[1], 2)};
	endproperty
	a_fmt0_ch1: assert property (p_fmt0_ch1) else $error("format 000 word wrong");

	property p_fmt1_ch1;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH1_DATA_HIGH && ctrl_reg[1][2:0] == 3'h1
		|=> ##1 ch1_conv_o.word == {$past(sfr_req_i.wdata[4:0], 2), $past(low_reg[1][7:1], 2)};
	endproperty
	a_fmt1_ch1: assert property (p_fmt1_ch1) else $error("format 001 word wrong");

	property p_fmt2_ch1;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH1_DATA_HIGH && ctrl_reg[1][2:0] == 3'h2
		|=> ##1 ch1_conv_o.word == {$past(sfr_req_i.wdata[5:0], 2), $past(low_reg[1][7:2], 2)};
	endproperty
	a_fmt2_ch1: assert property (p_fmt2_ch1) else $error("format 010 word wrong");

	property p_fmt3_ch1;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH1_DATA_HIGH && ctrl_reg[1][2:0] == 3'h3
		|=> ##1 ch1_conv_o.word == {$past(sfr_req_i.wdata[6:0], 2), $past(low_reg[1][7:3], 2)};
	endproperty
	a_fmt3_ch1: assert property (p_fmt3_ch1) else $error("format 011 word wrong");

	property p_fmt4_ch0;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH0_DATA_HIGH && ctrl_reg[0][2]
		|=> ##1 ch0_conv_o.word == {$past(sfr_req_i.wdata, 2), $past(low_reg[0][7:4], 2)};
	endproperty
	a_fmt4_ch0: assert property (p_fmt4_ch0) else $error("format 1xx word wrong");

	property p_word_only_on_high;
		@(posedge clk_sys_i) disable iff (reset_i)
		!(sfr_req_i.write && sfr_req_i.addr == ADDR_CH1_DATA_HIGH) |=> ##1 $stable(ch1_conv_o.word);
	endproperty
	a_word_only_on_high: assert property (p_word_only_on_high) else $error("word changed without high write");

	property p_enable_follows;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH1_CONTROL
		|=> ##1 ch1_conv_o.enable == $past(sfr_req_i.wdata[7], 2);
	endproperty
	a_enable_follows: assert property (p_enable_follows) else $error("enable does not follow control write");

	property p_high_reset;
		@(posedge clk_sys_i) reset_i |=> high_reg[1] == RESET_BYTE && low_reg[1] == RESET_BYTE && ctrl_reg[1] == RESET_BYTE;
	endproperty
	a_high_reset: assert property (p_high_reset) else $error("channel 1 registers not cleared by reset");

	property p_fmt0_ch0;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH0_DATA_HIGH && ctrl_reg[0][2:0] == 3'h0
		|=> ##1 ch0_conv_o.word == {$past(sfr_req_i.wdata[3:0], 2), $past(low_reg[0], 2)};
	endproperty
	a_fmt0_ch0: assert property (p_fmt0_ch0) else $error("channel 0 format 000 word wrong");

	property p_fmt1_ch0;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH0_DATA_HIGH && ctrl_reg[0][2:0] == 3'h1
		|=> ##1 ch0_conv_o.word == {$past(sfr_req_i.wdata[4:0], 2), $past(low_reg[0][7:1], 2)};
	endproperty
	a_fmt1_ch0: assert property (p_fmt1_ch0) else $error("channel 0 format 001 word wrong");

	property p_fmt2_ch0;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH0_DATA_HIGH && ctrl_reg[0][2:0] == 3'h2
		|=> ##1 ch0_conv_o.word == {$past(sfr_req_i.wdata[5:0], 2), $past(low_reg[0][7:2], 2)};
	endproperty
	a_fmt2_ch0: assert property (p_fmt2_ch0) else $error("channel 0 format 010 word wrong");

	property p_fmt3_ch0;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH0_DATA_HIGH && ctrl_reg[0][2:0] == 3'h3
		|=> ##1 ch0_conv_o.word == {$past(sfr_req_i.wdata[6:0], 2), $past(low_reg[0][7:3], 2)};
	endproperty
	a_fmt3_ch0: assert property (p_fmt3_ch0) else $error("channel 0 format 011 word wrong");

	property p_fmt4_ch1;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH1_DATA_HIGH && ctrl_reg[1][2]
		|=> ##1 ch1_conv_o.word == {$past(sfr_req_i.wdata, 2), $past(low_reg[1][7:4], 2)};
	endproperty
	a_fmt4_ch1: assert property (p_fmt4_ch1) else $error("channel 1 format 1xx word wrong");

	property p_enable_follows_ch0;
		@(posedge clk_sys_i) disable iff (reset_i)
		sfr_req_i.write && sfr_req_i.addr == ADDR_CH0_CONTROL
		|=> ##1 ch0_conv_o.enable == $past(sfr_req_i.wdata[7], 2);
	endproperty
	a_enable_follows_ch0: assert property (p_enable_follows_ch0) else $error("channel 0 enable wrong");

	property p_word_only_on_high_ch0;
		@(posedge clk_sys_i) disable iff (reset_i)
		!(sfr_req_i.write && sfr_req_i.addr == ADDR_CH0_DATA_HIGH) |=> ##1 $stable(ch0_conv_o.word);
	endproperty
	a_word_only_on_high_ch0: assert property (p_word_only_on_high_ch0) else $error("channel 0 word changed");

	property p_ch0_reset;
		@(posedge clk_sys_i) reset_i |=> high_reg[0] == RESET_BYTE && low_reg[0] == RESET_BYTE && ctrl_reg[0] == RESET_BYTE;
	endproperty
	a_ch0_reset: assert property (p_ch0_reset) else $error("channel 0 registers not cleared by reset");

endmodule

// ===== hdl/conv_format_pkg.sv
// constants and types for the two-channel converter register front end
// What this block does
// - enable 0: output off, converter shut down
// - enable 1: output driven, converter running
// - control bits 6:3 read zero, ignored
// - code 000: high[3:0] over whole low byte
// - code 001: high[4:0] over low[7:1]
// - code 010: high[5:0] over low[7:2]
// - code 011: high[6:0] over low[7:3]
// - code 1xx: whole high over low[7:4]
// - channel 1 high byte at 0xD6, resets zero
// - channel 1 low byte at 0xD5, resets zero
// - channel 1 control at 0xD7, resets zero
// - word latched only on high-byte write
// - channel 1 behaves like channel 0
// - latched word is twelve bits wide
package conv_format_pkg;
	localparam logic [7:0] ADDR_CH0_DATA_LOW  = 8'hD2;
	localparam logic [7:0] ADDR_CH0_DATA_HIGH = 8'hD3;
	localparam logic [7:0] ADDR_CH0_CONTROL   = 8'hD4;
	localparam logic [7:0] ADDR_CH1_DATA_LOW  = 8'hD5;
	localparam logic [7:0] ADDR_CH1_DATA_HIGH = 8'hD6;
	localparam logic [7:0] ADDR_CH1_CONTROL   = 8'hD7;
	localparam logic [7:0] RESET_BYTE         = 8'h00;
	localparam logic [11:0] RESET_WORD        = 12'h000;
	localparam int ENABLE_BIT                 = 7;
	localparam logic [7:0] CONTROL_MASK       = 8'h87;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_type;

	typedef struct packed {
		logic [11:0] word;
		logic        enable;
	} conv_out_type;
endpackage

// ===== test/test_conv_format_ctrl.sv
// self-checking bench for the converter register front end
module test_conv_format_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import conv_format_pkg::*;

	logic         clk_sys_i;
	logic         reset_i;
	sfr_req_type  req;
	logic [7:0]   rdata;
	conv_out_type ch0;
	conv_out_type ch1;
	int           n_mismatch;
	int           cmp_count;
	int           cycles;

	conv_format_ctrl i_conv_format_ctrl (
		.clk_sys_i   (clk_sys_i),
		.reset_i     (reset_i),
		.sfr_req_i   (req),
		.sfr_rdata_o (rdata),
		.ch0_conv_o  (ch0),
		.ch1_conv_o  (ch1)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	// expected word, worked out independently of the design
	function automatic logic [11:0] fmt(input logic [2:0] c, input logic [7:0] h, input logic [7:0] l);
		case (c)
			3'h0: fmt = {h[3:0], l};
			3'h1: fmt = {h[4:0], l[7:1]};
			3'h2: fmt = {h[5:0], l[7:2]};
			3'h3: fmt = {h[6:0], l[7:3]};
			default: fmt = {h, l[7:4]};
		endcase
	endfunction

	task automatic end_of_test;
		if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// one-cycle request pulse; outputs are given two extra cycles to land
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		req = '{write: wr, read: !wr, addr: a, wdata: d};
		@(negedge clk_sys_i);
		req = '0;
		repeat (2) @(negedge clk_sys_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		access(1'b0, a, 8'h00);
		chk({4'h0, rdata}, {4'h0, exp});
	endtask

	task automatic t_reset;
		rd(ADDR_CH1_DATA_LOW, 8'h00);
		rd(ADDR_CH1_DATA_HIGH, 8'h00);
		rd(ADDR_CH1_CONTROL, 8'h00);
		chk(ch1.word, 12'h000);
		chk({11'h0, ch1.enable}, 12'h000);
		chk({11'h0, ch0.enable}, 12'h000);
	endtask

	task automatic t_ctrl;
		access(1'b1, ADDR_CH1_CONTROL, 8'hFF);
		rd(ADDR_CH1_CONTROL, 8'h87);
		chk({11'h0, ch1.enable}, 12'h001);
		access(1'b1, ADDR_CH1_CONTROL, 8'h78);
		rd(ADDR_CH1_CONTROL, 8'h00);
		chk({11'h0, ch1.enable}, 12'h000);
		access(1'b1, 8'h10, 8'hFF);
		rd(8'h10, 8'h00);
	endtask

	// every format code on one channel; unused control bits set on purpose
	task automatic t_format(input logic [7:0] base);
		for (int c = 0; c < 8; c++) begin
			access(1'b1, base + 8'h2, {5'h1F, 3'(c)});
			access(1'b1, base, 8'hA5);
			access(1'b1, base + 8'h1, 8'hC7);
			chk((base == ADDR_CH1_DATA_LOW) ? ch1.word : ch0.word, fmt(3'(c), 8'hC7, 8'hA5));
		end
		chk({11'h0, (base == ADDR_CH1_DATA_LOW) ? ch1.enable : ch0.enable}, 12'h001);
		rd(base + 8'h1, 8'hC7);
	endtask

	task automatic t_latch;
		access(1'b1, ADDR_CH1_DATA_LOW, 8'h33);
		chk(ch1.word, fmt(3'h7, 8'hC7, 8'hA5));
		access(1'b1, ADDR_CH1_CONTROL, 8'h80);
		chk(ch1.word, fmt(3'h7, 8'hC7, 8'hA5));
		access(1'b1, ADDR_CH1_DATA_HIGH, 8'hFF);
		chk(ch1.word, 12'hF33);
		access(1'b1, ADDR_CH1_CONTROL, 8'h84);
		access(1'b1, ADDR_CH1_DATA_LOW, 8'hF0);
		access(1'b1, ADDR_CH1_DATA_HIGH, 8'hFF);
		chk(ch1.word, 12'hFFF);
	endtask

	// hang guard well above the few hundred cycles the run needs
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		cycles = 0;
		reset_i = 1'b1;
		req = '0;
		// count rising edges: the x-to-0 clock start must not pass for a falling edge
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		reset_i = 1'b0;
		t_reset();
		t_ctrl();
		t_format(ADDR_CH1_DATA_LOW);
		t_format(ADDR_CH0_DATA_LOW);
		t_latch();
		// second reset with nonzero state, outputs must clear again
		reset_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		reset_i = 1'b0;
		t_reset();
		end_of_test();
	end
endmodule
